/* File: verif/adcsq_core_model.sv */
/*
  Behavioural model of the analog multiplexer and conversion core.
  Assumes the control block presents reference, channel and power as
  registered levels and samples the code at its completion tick.
*/
`timescale 1ns/100ps

module adcsq_core_model
  import adcsq_pkg::*;
(
  input  wire logic       clk_i,      // System clock
  input  wire logic       power_i,    // Core powered
  input  wire logic [1:0] ref_i,      // Reference selection
  input  wire logic [3:0] channel_i,  // Channel selection
  output logic      [9:0] sample_o    // Code returned to the block
);
  int          vin_mv;
  int          vref_mv;
  int          code;
  logic  [9:0] junk = 10'h155;

  // --------------------------------------------------------------
  // Unpowered or unreferenced core shows a moving pattern
  // --------------------------------------------------------------
  // A stale code would hide a sample taken at the wrong moment.
  always @(posedge clk_i) begin
    junk <= ~junk;
  end

  always_comb begin
    case (ref_i)
      2'b00:   vref_mv = 2500;
      2'b01:   vref_mv = 3300;
      2'b11:   vref_mv = 1100;
      default: vref_mv = 0;
    endcase
    if (channel_i < 4'h8) begin
      vin_mv = 100 + 200 * int'(channel_i);
    end else if (channel_i == 4'he) begin
      vin_mv = 1100;
    end else begin
      vin_mv = 0;
    end
    code = (vref_mv == 0) ? 0 : vin_mv * 1024 / vref_mv;
    if (code > 1023) begin
      code = 1023;
    end
    sample_o = (!power_i || vref_mv == 0) ? junk : code[9:0];
  end
endmodule

/* File: verif/tb_top.sv */
/*
  Self-checking bench for the converter sequencer control block.
  Assumes the defines header is on the include path and the core model
  stands on the analog side.
*/
`timescale 1ns/100ps
`include "adcsq_defines.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  num_errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end

module tb_top;
  import adcsq_pkg::*;
  logic       clk = 0;
  logic       rstn = 0;
  logic [2:0] addr = 0;
  logic [7:0] wdata = 0;
  logic       wr_s = 0;
  logic       rd_s = 0;
  logic [7:0] trg = 0;
  logic       gie = 1;
  logic       vack = 0;
  logic [9:0] sample;
  logic [7:0] rdata;
  logic       irq, power, sampling, samp_d = 0;
  logic [1:0] ref_sel;
  logic [3:0] chan;
  int         num_errors = 0;
  int         n_compared = 0;
  int         hi_cnt = 0;
  int         n_rise = 0;
  int         r0;

  adcsq_control dut (.CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata),
    .TRIG_SRC_I(trg), .GLOBAL_IE_I(gie), .VECTOR_ACK_I(vack),
    .SAMPLE_I(sample), .IRQ_O(irq), .POWER_O(power),
    .SAMPLING_O(sampling), .REF_O(ref_sel), .CHANNEL_O(chan));
  adcsq_core_model core (.clk_i(clk), .power_i(power), .ref_i(ref_sel),
    .channel_i(chan), .sample_o(sample));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // Length of each busy period, counted in system clocks.
  always @(posedge clk) begin
    if (sampling && !samp_d) begin
      hi_cnt <= 1;
      n_rise <= n_rise + 1;
    end else if (sampling) begin
      hi_cnt <= hi_cnt + 1;
    end
    samp_d <= sampling;
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    `CHK("read data", e, rdata)
  endtask

  task automatic conv_check(input int rise0, input int e);
    int k;
    for (k = 0; k < 5000; k++) begin
      @(posedge clk);
      #1;
      if (n_rise > rise0 && sampling === 1'b0) break;
    end
    `CHK("busy cycles", e, hi_cnt)
  endtask

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    stop_test();
  end

  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(`ADCSQ_OFF_SEL, 8'h00);
    rd(`ADCSQ_OFF_CTL, 8'h00);
    rd(`ADCSQ_OFF_RLO, 8'h00);
    rd(`ADCSQ_OFF_RHI, 8'h00);
    rd(`ADCSQ_OFF_TRG, 8'h00);
    wr(3'h5, 8'hff);
    rd(3'h5, 8'h00);
    wr(`ADCSQ_OFF_SEL, 8'hff);
    rd(`ADCSQ_OFF_SEL, 8'hef);
    `CHK("reference", 2'b11, ref_sel)
    wr(`ADCSQ_OFF_CTL, 8'h40);
    rd(`ADCSQ_OFF_CTL, 8'h00);
    // First conversion: channel 3, external reference, divide by 2.
    wr(`ADCSQ_OFF_SEL, 8'h03);
    r0 = n_rise;
    wr(`ADCSQ_OFF_CTL, 8'hc0);
    rd(`ADCSQ_OFF_CTL, 8'hc0);
    wr(`ADCSQ_OFF_CTL, 8'h80);
    rd(`ADCSQ_OFF_CTL, 8'hc0);
    wr(`ADCSQ_OFF_SEL, 8'h05);
    #1;
    `CHK("locked channel", 4'h3, chan)
    `CHK("power", 1'b1, power)
    conv_check(r0, 50);
    rd(`ADCSQ_OFF_RLO, 8'h1e);
    `CHK("idle channel", 4'h5, chan)
    rd(`ADCSQ_OFF_RHI, 8'h01);
    rd(`ADCSQ_OFF_CTL, 8'h90);
    `CHK("irq", 1'b0, irq)
    // Writing back the value just read clears the pending flag.
    wr(`ADCSQ_OFF_CTL, 8'h90);
    rd(`ADCSQ_OFF_CTL, 8'h80);
    wr(`ADCSQ_OFF_SEL, 8'h25);
    rd(`ADCSQ_OFF_RHI, 8'h47);
    rd(`ADCSQ_OFF_RLO, 8'h80);
    // Low byte read above keeps the old result until the high byte.
    r0 = n_rise;
    wr(`ADCSQ_OFF_CTL, 8'hd8);
    rd(`ADCSQ_OFF_CTL, 8'hc8);
    conv_check(r0, 26);
    rd(`ADCSQ_OFF_RHI, 8'h47);
    `CHK("irq", 1'b1, irq)
    gie <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("irq", 1'b0, irq)
    gie  <= 1'b1;
    vack <= 1'b1;
    @(posedge clk);
    vack <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("irq", 1'b0, irq)
    for (int k = 0; k < 8; k++) begin
      r0 = n_rise;
      wr(`ADCSQ_OFF_CTL, 8'hc0 | 8'(k));
      conv_check(r0, 13 * ((k == 0) ? 2 : (1 << k)));
    end
    rd(`ADCSQ_OFF_RLO, 8'h80);
    rd(`ADCSQ_OFF_RHI, 8'h70);
    wr(`ADCSQ_OFF_CTL, 8'hc0);
    repeat (20) @(posedge clk);
    #1;
    `CHK("busy", 1'b1, sampling)
    wr(`ADCSQ_OFF_CTL, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    `CHK("busy", 1'b0, sampling)
    `CHK("power", 1'b0, power)
    rd(`ADCSQ_OFF_CTL, 8'h10);
    wr(`ADCSQ_OFF_TRG, 8'h01);
    wr(`ADCSQ_OFF_SEL, 8'h03);
    r0 = n_rise;
    wr(`ADCSQ_OFF_CTL, 8'hb0);
    trg <= 8'h02;
    conv_check(r0, 50);
    rd(`ADCSQ_OFF_CTL, 8'hb0);
    trg <= 8'h00;
    wr(`ADCSQ_OFF_TRG, 8'h00);
    repeat (60) @(posedge clk);
    `CHK("busy starts", r0 + 1, n_rise)
    // Free running: one start, then the next conversion follows alone.
    r0 = n_rise;
    wr(`ADCSQ_OFF_CTL, 8'he0);
    conv_check(r0, 26);
    conv_check(r0 + 1, 26);
    stop_test();
  end
endmodule

/* File: verilog/adcsq_control.sv */
/*
  Converter sequencer control: selection and control registers, clock
  prescaler, conversion timing and result presentation.
  Assumes an analog core that returns a 10-bit code on SAMPLE_I when
  asked, a processor that acknowledges the interrupt vector, and a
  register master following the one-cycle strobe protocol.
*/
`timescale 1ns/100ps
`include "adcsq_defines.svh"

// Behaviour
// - Result code is Vin*1024/Vref; 0x000 ground, 0x3FF reference minus LSB.
// - Completed conversion value shows in the low and high result registers.
// - Bits 7:6 pick external, supply, reserved or internal 1.1V reference.
// - Reference and channel changes mid-conversion apply only after completion.
// - Left adjust bit 5 changes the result view at once, even mid-conversion.
// - Selection register bit 4 always reads zero.
// - Channel codes 0-7 inputs, 1110 bandgap, 1111 ground, others reserved.
// - Enable bit 7 powers converter; clearing it aborts a running conversion.
// - Start bit launches single conversions, or the first free-running one.
// - First conversion after enabling takes 25 converter clocks, else 13.
// - Start bit reads one while converting; writing zero does nothing.
// - Auto-trigger enable starts a conversion per rising trigger edge seen while idle; edges mid-conversion are dropped.
// - Done flag sets when a conversion ends, whether or not frozen results are updated.
// - Interrupt requested only when flag, enable and global enable all set.
// - Done flag clears on vector execution or a written one.
// - Divider codes 000,001 give 2, then 4 up to 128 for 111.
// - Reading low result freezes both result registers until high is read.
// - Trigger source zero is free running; switching to it never triggers.
// - Right adjust puts bits 9:8 high; left adjust puts 9:2 high, 1:0 low.
module adcsq_control
  import adcsq_pkg::*;
(
  input  wire logic       CLK_I,          // System clock, 200 MHz
  input  wire logic       RSTN_I,         // Synchronous reset, active low
  input  wire logic [2:0] ADDR_I,         // Register address
  input  wire logic [7:0] WDATA_I,        // Write data
  input  wire logic       WR_I,           // Write strobe
  input  wire logic       RD_I,           // Read strobe
  output logic      [7:0] RDATA_O,        // Read data, cycle after strobe
  input  wire logic [7:0] TRIG_SRC_I,     // Trigger flags, index 1..7 used
  input  wire logic       GLOBAL_IE_I,    // Processor global interrupt enable
  input  wire logic       VECTOR_ACK_I,   // Interrupt vector executed
  input  wire logic [9:0] SAMPLE_I,       // Code from the analog core
  output logic            IRQ_O,          // Conversion complete request
  output logic            POWER_O,        // Analog core powered
  output logic            SAMPLING_O,     // Conversion in progress
  output logic      [1:0] REF_O,          // Reference used by the core
  output logic      [3:0] CHANNEL_O       // Channel used by the core
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  adcsq_sel_s   sel_reg, sel_next;
  adcsq_ctl_s   ctl_reg, ctl_next;
  logic [2:0]   trg_reg, trg_next;
  logic [9:0]   res_reg, res_next;
  logic         frz_reg, frz_next;
  logic [1:0]   lref_reg, lref_next;
  logic [3:0]   lch_reg, lch_next;
  logic [6:0]   pre_reg, pre_next;
  logic [4:0]   cyc_reg, cyc_next;
  logic         init_reg, init_next;
  logic         tprev_reg, tprev_next;
  logic [7:0]   rd_reg, rd_next;
  adcsq_state_e st_reg, st_next;

  logic         wr_sel, wr_ctl, wr_trg, tick, trig_now, start_req;
  logic         done_evt;
  logic [6:0]   div_mask;
  logic [15:0]  view;

  assign wr_sel = WR_I && (ADDR_I == `ADCSQ_OFF_SEL);
  assign wr_ctl = WR_I && (ADDR_I == `ADCSQ_OFF_CTL);
  assign wr_trg = WR_I && (ADDR_I == `ADCSQ_OFF_TRG);

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  always_comb begin
    unique case (ctl_reg.clock_divider_select)
      3'd0, 3'd1: div_mask = 7'h01;
      3'd2:       div_mask = 7'h03;
      3'd3:       div_mask = 7'h07;
      3'd4:       div_mask = 7'h0f;
      3'd5:       div_mask = 7'h1f;
      3'd6:       div_mask = 7'h3f;
      3'd7:       div_mask = 7'h7f;
    endcase
  end

  // Counter is held at zero while off so edges start at a known phase.
  assign pre_next = ctl_reg.converter_enable ? 7'(pre_reg + 7'd1)
                                             : 7'h00;
  assign tick = ctl_reg.converter_enable &&
                ((pre_reg & div_mask) == div_mask);

  // ----------------------------------------------------------------
  // Trigger edge detection
  // ----------------------------------------------------------------
  // The flag source level follows the selection, so a switch to a set
  // source yields an edge; free running has no edge source at all.
  logic trig_lvl;
  assign trig_lvl   = (trg_reg != 3'd0) && TRIG_SRC_I[trg_reg];
  assign tprev_next = trig_lvl;
  assign trig_now   = ctl_reg.auto_trigger_enable && ctl_reg.converter_enable
                      && (((trg_reg != 3'd0) && trig_lvl && !tprev_reg)
                      || ((trg_reg == 3'd0) && st_reg == ADCSQ_IDLE &&
                          init_reg == 1'b0 && ctl_reg.conversion_start));

  // ----------------------------------------------------------------
  // Sequencer and registers
  // ----------------------------------------------------------------
  always_comb begin
    sel_next  = sel_reg;
    ctl_next  = ctl_reg;
    trg_next  = trg_reg;
    res_next  = res_reg;
    frz_next  = frz_reg;
    lref_next = lref_reg;
    lch_next  = lch_reg;
    cyc_next  = cyc_reg;
    init_next = init_reg;
    st_next   = st_reg;
    done_evt  = 1'b0;
    start_req = 1'b0;
    if (wr_sel) begin
      sel_next        = adcsq_sel_s'(WDATA_I);
      sel_next.unused = 1'b0;
    end
    if (wr_trg)
      trg_next = WDATA_I[2:0];
    if (wr_ctl) begin
      ctl_next.converter_enable      = WDATA_I[`ADCSQ_CTL_EN];
      ctl_next.auto_trigger_enable   = WDATA_I[`ADCSQ_CTL_AUTO];
      ctl_next.done_interrupt_enable = WDATA_I[`ADCSQ_CTL_IE];
      ctl_next.clock_divider_select  = WDATA_I[2:0];
      if (WDATA_I[`ADCSQ_CTL_START] && WDATA_I[`ADCSQ_CTL_EN])
        ctl_next.conversion_start = 1'b1;
      if (WDATA_I[`ADCSQ_CTL_DONE])
        ctl_next.conversion_done_flag = 1'b0;
      if (WDATA_I[`ADCSQ_CTL_EN] && !ctl_reg.converter_enable)
        init_next = 1'b1;
    end
    if (VECTOR_ACK_I)
      ctl_next.conversion_done_flag = 1'b0;
    if (RD_I && ADDR_I == `ADCSQ_OFF_RLO)
      frz_next = 1'b1;
    if (RD_I && ADDR_I == `ADCSQ_OFF_RHI)
      frz_next = 1'b0;
    unique case (st_reg)
      ADCSQ_IDLE: begin
        // Selection tracks the register until a conversion locks it.
        lref_next = sel_next.reference_select;
        lch_next  = sel_next.channel_select;
        // A pending start, from software or from a trigger edge that fell
        // between converter clock edges, launches at the next tick.
        if (tick && (trig_now || ctl_reg.conversion_start)) begin
          start_req = 1'b1;
          st_next   = ADCSQ_CONV;
          cyc_next  = init_reg ? `ADCSQ_CYC_FIRST : `ADCSQ_CYC_NORMAL;
          ctl_next.conversion_start = 1'b1;
        end else if (trig_now) begin
          ctl_next.conversion_start = 1'b1;
        end
      end
      ADCSQ_CONV: begin
        if (tick) begin
          if (cyc_reg == 5'd1) begin
            done_evt  = 1'b1;
            init_next = 1'b0;
            st_next   = ADCSQ_IDLE;
            ctl_next.conversion_start = 1'b0;
            if (!frz_next)
              res_next = SAMPLE_I;
            ctl_next.conversion_done_flag = 1'b1;
            if (ctl_reg.auto_trigger_enable && trg_reg == 3'd0)
              ctl_next.conversion_start = 1'b1;
          end else begin
            cyc_next = 5'(cyc_reg - 5'd1);
          end
        end
      end
      default: st_next = ADCSQ_IDLE;
    endcase
    if (!ctl_next.converter_enable) begin
      st_next   = ADCSQ_IDLE;
      ctl_next.conversion_start = 1'b0;
      init_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Result view and read port
  // ----------------------------------------------------------------
  assign view = sel_reg.left_adjust_result
              ? {res_reg, 6'h00}
              : {6'h00, res_reg};

  always_comb begin
    rd_next = `ADCSQ_RST_BYTE;
    if (RD_I) begin
      unique case (ADDR_I)
        `ADCSQ_OFF_SEL: rd_next = sel_reg;
        `ADCSQ_OFF_CTL: rd_next = ctl_reg;
        `ADCSQ_OFF_RLO: rd_next = view[7:0];
        `ADCSQ_OFF_RHI: rd_next = view[15:8];
        `ADCSQ_OFF_TRG: rd_next = {5'h00, trg_reg};
        default:        rd_next = `ADCSQ_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      sel_reg   <= adcsq_sel_s'(`ADCSQ_RST_BYTE);
      ctl_reg   <= adcsq_ctl_s'(`ADCSQ_RST_BYTE);
      trg_reg   <= 3'h0;
      res_reg   <= 10'h000;
      frz_reg   <= 1'b0;
      lref_reg  <= 2'h0;
      lch_reg   <= 4'h0;
      pre_reg   <= 7'h00;
      cyc_reg   <= 5'h00;
      init_reg  <= 1'b0;
      tprev_reg <= 1'b0;
      rd_reg    <= 8'h00;
      st_reg    <= ADCSQ_IDLE;
    end else begin
      sel_reg   <= sel_next;
      ctl_reg   <= ctl_next;
      trg_reg   <= trg_next;
      res_reg   <= res_next;
      frz_reg   <= frz_next;
      lref_reg  <= lref_next;
      lch_reg   <= lch_next;
      pre_reg   <= pre_next;
      cyc_reg   <= cyc_next;
      init_reg  <= init_next;
      tprev_reg <= tprev_next;
      rd_reg    <= rd_next;
      st_reg    <= st_next;
    end
  end

  assign RDATA_O    = rd_reg;
  assign IRQ_O      = ctl_reg.conversion_done_flag && GLOBAL_IE_I &&
                      ctl_reg.done_interrupt_enable;
  assign POWER_O    = ctl_reg.converter_enable;
  assign SAMPLING_O = (st_reg == ADCSQ_CONV);
  assign REF_O      = lref_reg;
  assign CHANNEL_O  = lch_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // The request is a plain gate of the flag; a sticky request would
  // re-enter the handler after the vector has already cleared the flag.
  a_irq_gating: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    IRQ_O == (ctl_reg.conversion_done_flag && ctl_reg.done_interrupt_enable
              && GLOBAL_IE_I))
    else $error("interrupt request not gated correctly");
  a_abort_on_off: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    (wr_ctl && !WDATA_I[7]) |=> (!SAMPLING_O && !ctl_reg.conversion_start))
    else $error("disable did not abort conversion");
  a_done_sets: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    done_evt |=> ctl_reg.conversion_done_flag)
    else $error("done flag not set on completion");
  a_start_busy: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    SAMPLING_O |-> ctl_reg.conversion_start)
    else $error("start bit low while converting");
  a_sel_locked: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    (SAMPLING_O && $past(SAMPLING_O)) |-> $stable(CHANNEL_O))
    else $error("channel changed mid conversion");
  a_bit4_zero: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    $past(RD_I && ADDR_I == `ADCSQ_OFF_SEL) |-> !RDATA_O[4])
    else $error("reserved bit read as one");
  a_prescale_off: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    !ctl_reg.converter_enable |=> pre_reg == 7'h00)
    else $error("prescaler ran while disabled");
  a_freeze_hold: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    (frz_reg && frz_next) |=> $stable(res_reg))
    else $error("result changed while frozen");
  a_start_launch: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    (st_reg == ADCSQ_IDLE && tick && ctl_reg.conversion_start &&
     ctl_next.converter_enable) |=> SAMPLING_O)
    else $error("pending start did not launch a conversion");
  a_first_len: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    start_req |=> (cyc_reg == ($past(init_reg) ? `ADCSQ_CYC_FIRST
                                               : `ADCSQ_CYC_NORMAL)))
    else $error("conversion length loaded wrongly");

endmodule

/* File: verilog/adcsq_defines.svh */
/*
  Register offsets, field positions, reset values and timing counts
  for the converter sequencer control block.
  Assumes inclusion by bare name from the package and the design.
*/
`ifndef ADCSQ_DEFINES_SVH
`define ADCSQ_DEFINES_SVH

// ----------------------------------------------------------------
// Register map (byte offsets on the plain register port)
// ----------------------------------------------------------------
`define ADCSQ_OFF_SEL    3'h0
`define ADCSQ_OFF_CTL    3'h1
`define ADCSQ_OFF_RLO    3'h2
`define ADCSQ_OFF_RHI    3'h3
`define ADCSQ_OFF_TRG    3'h4
`define ADCSQ_RST_BYTE   8'h00

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define ADCSQ_CTL_EN     7
`define ADCSQ_CTL_START  6
`define ADCSQ_CTL_AUTO   5
`define ADCSQ_CTL_DONE   4
`define ADCSQ_CTL_IE     3

// ----------------------------------------------------------------
// Conversion lengths in converter clock cycles, channel codes and code limit
// ----------------------------------------------------------------
`define ADCSQ_CYC_FIRST  5'd25
`define ADCSQ_CYC_NORMAL 5'd13
`define ADCSQ_CH_BG      4'he
`define ADCSQ_CH_GND     4'hf
`define ADCSQ_CODE_MAX   10'h3ff

`endif

/* File: verilog/adcsq_pkg.sv */
/*
  Types for the converter sequencer control block.
  Assumes the defines header is on the include path.
*/
package adcsq_pkg;
  `include "adcsq_defines.svh"

  typedef enum logic [1:0] {
    ADCSQ_REF_EXT, ADCSQ_REF_SUPPLY, ADCSQ_REF_RSVD, ADCSQ_REF_BANDGAP
  } adcsq_ref_e;

  typedef struct packed {
    adcsq_ref_e  reference_select;
    logic        left_adjust_result;
    logic        unused;
    logic [3:0]  channel_select;
  } adcsq_sel_s;

  typedef struct packed {
    logic        converter_enable;
    logic        conversion_start;
    logic        auto_trigger_enable;
    logic        conversion_done_flag;
    logic        done_interrupt_enable;
    logic [2:0]  clock_divider_select;
  } adcsq_ctl_s;

  typedef enum logic [1:0] {ADCSQ_IDLE, ADCSQ_CONV} adcsq_state_e;
endpackage
